// File: verilog/cmd_src_pkg.sv
package cmd_src_pkg;
  // ************************************************************
  // operation mode selection values
  // ************************************************************
  localparam logic [2:0] MODE_SEL_EXT_FREE  = 3'h0;
  localparam logic [2:0] MODE_SEL_PU_FIXED  = 3'h1;
  localparam logic [2:0] MODE_SEL_EXT_FIXED = 3'h2;
  localparam logic [2:0] MODE_SEL_COMB1     = 3'h3;
  localparam logic [2:0] MODE_SEL_COMB2     = 3'h4;
  localparam logic [2:0] MODE_SEL_RESET     = 3'h0;

  // ************************************************************
  // register offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] OFF_MODE_SEL   = 8'h00;
  localparam logic [7:0] OFF_CONTROL    = 8'h04;
  localparam logic [7:0] OFF_STATUS     = 8'h08;
  localparam logic [7:0] OFF_KEY_FREQ   = 8'h0c;
  localparam logic [7:0] OFF_PARAM_WR   = 8'h10;
  localparam logic [7:0] OFF_FREQ_OUT   = 8'h14;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int CTRL_DIAL_LOCK   = 0;
  localparam int STAT_KEYPAD_MODE = 0;
  localparam int STAT_RUN         = 1;
  localparam int STAT_REVERSE     = 2;
  localparam int STAT_WR_REJECT   = 3;
  localparam int STAT_MODE_LSB    = 4;
  localparam int STAT_SRC_LSB     = 8;
  localparam int PWR_PROTECT_BIT  = 8;

  // ************************************************************
  // bus answers and widths
  // ************************************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int         FREQ_W      = 16;
  localparam logic [15:0] FREQ_RESET = 16'h0000;

  // ************************************************************
  // frequency sources
  // ************************************************************
  typedef enum logic [2:0] {
    SRC_KEYPAD, SRC_DIAL, SRC_MULTI, SRC_LOOP, SRC_TERM4, SRC_TERM2, SRC_INCH, SRC_LINK
  } freq_src_type;
endpackage

// File: verilog/in_sync.sv
`timescale 1ns/1ps
// two flip-flop synchroniser for a group of pin inputs
module in_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_reg;

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta_reg <= '0;
      dout     <= '0;
    end else begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end
endmodule // in_sync

// File: verilog/freq_pick.sv
`timescale 1ns/1ps
// combinational pick of frequency source by mode and priority
module freq_pick (
  input  wire logic                       keypad_mode,
  input  wire logic [2:0]                 mode_sel,
  input  wire logic                       multi_on,
  input  wire logic                       loop_on,
  input  wire logic                       current_input_choose,
  input  wire logic                       inch_run_signal,
  input  wire logic                       dial_lock,
  input  wire logic                       link_valid,
  output cmd_src_pkg::freq_src_type       src
);
  // ************************************************************
  // priority chain
  // ************************************************************
  always_comb begin
    src = cmd_src_pkg::SRC_TERM2;
    if (mode_sel == cmd_src_pkg::MODE_SEL_COMB1) begin
      if (multi_on) src = cmd_src_pkg::SRC_MULTI;
      else if (loop_on) src = cmd_src_pkg::SRC_LOOP;
      else if (current_input_choose) src = cmd_src_pkg::SRC_TERM4;
      else src = cmd_src_pkg::SRC_KEYPAD;
    end else if (keypad_mode) begin
      // a held link command wins; else dial acts as potentiometer unless locked
      if (link_valid) src = cmd_src_pkg::SRC_LINK;
      else if (dial_lock) src = cmd_src_pkg::SRC_KEYPAD;
      else src = cmd_src_pkg::SRC_DIAL;
    end else begin
      if (inch_run_signal) src = cmd_src_pkg::SRC_INCH;
      else if (multi_on) src = cmd_src_pkg::SRC_MULTI;
      else if (current_input_choose) src = cmd_src_pkg::SRC_TERM4;
      else src = cmd_src_pkg::SRC_TERM2;
    end
  end
endmodule // freq_pick

// File: verilog/drive_command_source_selector.sv
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ps
// Overview of operation
// - modes 0 and 2 come up in outside-terminal operation at power-on.
// - mode 2 locks outside-terminal operation; switch requests are refused.
// - mode 0: mode-toggle key moves outside-terminal operation into keypad mode.
// - outside-terminal mode rejects parameter writes except a protected-free subset.
// - outside-terminal: start from forward/backward inputs, frequency from terminals.
// - mode 1: keypad mode at power-on, keypad start and frequency, no change.
// - serial link commands accepted only in keypad mode.
// - keypad mode: dial adjusts frequency unless dial key-lock set or a link command is held.
// - mode 3: keypad frequency, external start switches, no mode change.
// - mode 3: active multi-speed selection overrides keypad frequency.
// - mode 3: current_input_choose selects terminal 4 analog input.
// - mode 4: terminal frequency, start from panel go/forward/backward keys.
// - mode 3 priority: multi-speed, process loop, terminal 4, keypad.
// - mode selection accepted only while motor output is stopped.
module drive_command_source_selector #(
  parameter int FW = cmd_src_pkg::FREQ_W
) (
  input  wire logic          REF_CLK,
  input  wire logic          NRST,
  // AXI4-Lite slave
  input  wire logic [7:0]    S_AXI_AWADDR,
  input  wire logic          S_AXI_AWVALID,
  output logic               S_AXI_AWREADY,
  input  wire logic [31:0]   S_AXI_WDATA,
  input  wire logic [3:0]    S_AXI_WSTRB,
  input  wire logic          S_AXI_WVALID,
  output logic               S_AXI_WREADY,
  output logic [1:0]         S_AXI_BRESP,
  output logic               S_AXI_BVALID,
  input  wire logic          S_AXI_BREADY,
  input  wire logic [7:0]    S_AXI_ARADDR,
  input  wire logic          S_AXI_ARVALID,
  output logic               S_AXI_ARREADY,
  output logic [31:0]        S_AXI_RDATA,
  output logic [1:0]         S_AXI_RRESP,
  output logic               S_AXI_RVALID,
  input  wire logic          S_AXI_RREADY,
  // terminal and keypad pins
  input  wire logic          FORWARD_START,
  input  wire logic          BACKWARD_START,
  input  wire logic          CURRENT_INPUT_CHOOSE,
  input  wire logic          SPEED_SELECT_LOW,
  input  wire logic          SPEED_SELECT_MID,
  input  wire logic          SPEED_SELECT_HIGH,
  input  wire logic          SPEED_SELECT_EXTRA,
  input  wire logic          PROCESS_LOOP_ENABLE,
  input  wire logic          INCH_RUN_SIGNAL,
  input  wire logic          MODE_TOGGLE_KEY,
  input  wire logic          PANEL_GO_KEY,
  input  wire logic          PANEL_FORWARD_KEY,
  input  wire logic          PANEL_BACKWARD_KEY,
  input  wire logic          PANEL_STOP_KEY,
  // frequency values from the drive side (same clock)
  input  wire logic [FW-1:0] TERM2_FREQ,
  input  wire logic [FW-1:0] TERM4_FREQ,
  input  wire logic [FW-1:0] MULTI_FREQ,
  input  wire logic [FW-1:0] LOOP_FREQ,
  input  wire logic [FW-1:0] INCH_FREQ,
  input  wire logic [FW-1:0] DIAL_FREQ,
  // serial link command (same clock)
  input  wire logic          LINK_CMD_VALID,
  input  wire logic          LINK_CMD_RUN,
  input  wire logic          LINK_CMD_REVERSE,
  input  wire logic [FW-1:0] LINK_CMD_FREQ,
  input  wire logic          MOTOR_STOPPED,
  // to the drive
  output logic               RUN_CMD,
  output logic               REVERSE_CMD,
  output logic [FW-1:0]      FREQ_CMD,
  output logic               KEYPAD_MODE,
  output logic               LINK_CMD_TAKEN
);
  // ************************************************************
  // pin synchronisers
  // ************************************************************
  localparam int NPIN = 14;
  logic [NPIN-1:0] pins_s;
  in_sync #(.WIDTH(NPIN)) u_sync (
    .clk  (REF_CLK),
    .nrst (NRST),
    .din  ({PANEL_STOP_KEY, PANEL_BACKWARD_KEY, PANEL_FORWARD_KEY, PANEL_GO_KEY,
            MODE_TOGGLE_KEY, INCH_RUN_SIGNAL, PROCESS_LOOP_ENABLE, SPEED_SELECT_EXTRA,
            SPEED_SELECT_HIGH, SPEED_SELECT_MID, SPEED_SELECT_LOW, CURRENT_INPUT_CHOOSE,
            BACKWARD_START, FORWARD_START}),
    .dout (pins_s)
  );
  logic fwd_s, bwd_s, cic_s, multi_s, loop_s, inch_s, tog_s, go_s, pfwd_s, pbwd_s, stop_s;
  assign fwd_s   = pins_s[0];
  assign bwd_s   = pins_s[1];
  assign cic_s   = pins_s[2];
  assign multi_s = |pins_s[6:3];
  assign loop_s  = pins_s[7];
  assign inch_s  = pins_s[8];
  assign tog_s   = pins_s[9];
  assign go_s    = pins_s[10];
  assign pfwd_s  = pins_s[11];
  assign pbwd_s  = pins_s[12];
  assign stop_s  = pins_s[13];

  // ************************************************************
  // register state
  // ************************************************************
  logic [2:0]    mode_sel_reg;
  logic          dial_lock_reg;
  logic [FW-1:0] key_freq_reg;
  logic          keypad_reg;
  logic          tog_prev_reg;
  logic          wr_reject_reg;
  logic [15:0]   param_store_reg;
  logic          panel_run_reg;
  logic          panel_rev_reg;
  logic          link_run_reg;
  logic          link_rev_reg;
  logic [FW-1:0] link_freq_reg;
  logic          link_valid_reg;
  logic          wr_ok;
  logic          rd_fire;

  // ************************************************************
  // AXI4-Lite write channel
  // ************************************************************
  logic       aw_held_reg, w_held_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        wr_fire;
  assign wr_fire = aw_held_reg && w_held_reg && !S_AXI_BVALID;

  // address and data taken in either order, then one response
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h00000000;
      w_strb_reg    <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= cmd_src_pkg::RESP_OKAY;
    end else begin
      S_AXI_AWREADY <= !aw_held_reg && !S_AXI_AWREADY && !S_AXI_BVALID;
      S_AXI_WREADY  <= !w_held_reg && !S_AXI_WREADY && !S_AXI_BVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held_reg <= 1'b1;
        w_data_reg <= S_AXI_WDATA;
        w_strb_reg <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_ok ? cmd_src_pkg::RESP_OKAY : cmd_src_pkg::RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // ************************************************************
  // write decode
  // ************************************************************
  logic       mode_wr_ok;
  logic       param_wr_ok;
  logic [2:0] new_mode;
  assign new_mode = w_data_reg[2:0];
  // values above four are not supported
  assign mode_wr_ok = MOTOR_STOPPED && (w_data_reg[31:3] == 29'h0)
                      && (new_mode <= cmd_src_pkg::MODE_SEL_COMB2) && w_strb_reg[0];
  // guarded bank closed in outside-terminal mode
  assign param_wr_ok = keypad_reg || !w_data_reg[cmd_src_pkg::PWR_PROTECT_BIT];
  always_comb begin
    case (aw_addr_reg)
      cmd_src_pkg::OFF_MODE_SEL: wr_ok = mode_wr_ok;
      cmd_src_pkg::OFF_CONTROL:  wr_ok = 1'b1;
      cmd_src_pkg::OFF_KEY_FREQ: wr_ok = 1'b1;
      cmd_src_pkg::OFF_PARAM_WR: wr_ok = param_wr_ok;
      default:                   wr_ok = 1'b0;
    endcase
  end

  // registers written by software
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      mode_sel_reg    <= cmd_src_pkg::MODE_SEL_RESET;
      dial_lock_reg   <= 1'b0;
      key_freq_reg    <= cmd_src_pkg::FREQ_RESET;
      param_store_reg <= 16'h0000;
    end else if (wr_fire && wr_ok) begin
      case (aw_addr_reg)
        cmd_src_pkg::OFF_MODE_SEL: mode_sel_reg  <= new_mode;
        cmd_src_pkg::OFF_CONTROL:  dial_lock_reg <= w_data_reg[cmd_src_pkg::CTRL_DIAL_LOCK];
        cmd_src_pkg::OFF_KEY_FREQ: key_freq_reg  <= w_data_reg[FW-1:0];
        cmd_src_pkg::OFF_PARAM_WR: param_store_reg <= w_data_reg[15:0];
        default: ;
      endcase
    end
  end

  // sticky reject flag; a new reject wins over the clear
  always_ff @(posedge REF_CLK) begin
    if (!NRST) wr_reject_reg <= 1'b0;
    else if (wr_fire && !wr_ok) wr_reject_reg <= 1'b1;
    else if (rd_fire && S_AXI_ARADDR == cmd_src_pkg::OFF_STATUS) wr_reject_reg <= 1'b0;
  end

  // ************************************************************
  // operation mode state
  // ************************************************************
  logic mode_changed;
  assign mode_changed = wr_fire && wr_ok && (aw_addr_reg == cmd_src_pkg::OFF_MODE_SEL);
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      // reset value 0 gives outside-terminal mode
      keypad_reg   <= 1'b0;
      tog_prev_reg <= 1'b0;
    end else begin
      tog_prev_reg <= tog_s;
      if (mode_changed) begin
        // mode 1 enters keypad mode; others come up outside
        keypad_reg <= (new_mode == cmd_src_pkg::MODE_SEL_PU_FIXED);
      end else if (tog_s && !tog_prev_reg && MOTOR_STOPPED
                   && mode_sel_reg == cmd_src_pkg::MODE_SEL_EXT_FREE) begin
        // toggle key flips mode 0 only
        // mode 2 never reaches this branch
        keypad_reg <= !keypad_reg;
      end
    end
  end

  // ************************************************************
  // serial link and panel keys
  // ************************************************************
  logic link_take;
  // link commands only in keypad mode
  assign link_take = LINK_CMD_VALID && keypad_reg;
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      link_run_reg   <= 1'b0;
      link_rev_reg   <= 1'b0;
      link_freq_reg  <= cmd_src_pkg::FREQ_RESET;
      link_valid_reg <= 1'b0;
    end else if (!keypad_reg) begin
      link_valid_reg <= 1'b0;
      link_run_reg   <= 1'b0;
    end else if (link_take) begin
      link_run_reg   <= LINK_CMD_RUN;
      link_rev_reg   <= LINK_CMD_REVERSE;
      link_freq_reg  <= LINK_CMD_FREQ;
      link_valid_reg <= 1'b1;
    end
  end

  // panel run latch; stop key always ends the run
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      panel_run_reg <= 1'b0;
      panel_rev_reg <= 1'b0;
    end else if (stop_s) begin
      panel_run_reg <= 1'b0;
    end else if (pfwd_s || pbwd_s || go_s) begin
      panel_run_reg <= 1'b1;
      if (pbwd_s) panel_rev_reg <= 1'b1;
      else if (pfwd_s) panel_rev_reg <= 1'b0;
    end
  end

  // ************************************************************
  // command routing
  // ************************************************************
  cmd_src_pkg::freq_src_type src;
  freq_pick u_pick (
    .keypad_mode          (keypad_reg),
    .mode_sel             (mode_sel_reg),
    .multi_on             (multi_s),
    .loop_on              (loop_s),
    .current_input_choose (cic_s),
    .inch_run_signal      (inch_s),
    .dial_lock            (dial_lock_reg),
    .link_valid           (link_valid_reg),
    .src                  (src)
  );

  logic          run_next, rev_next;
  logic [FW-1:0] freq_next;
  always_comb begin
    case (src)
      cmd_src_pkg::SRC_KEYPAD: freq_next = key_freq_reg;
      cmd_src_pkg::SRC_DIAL:   freq_next = DIAL_FREQ;
      cmd_src_pkg::SRC_MULTI:  freq_next = MULTI_FREQ;
      cmd_src_pkg::SRC_LOOP:   freq_next = LOOP_FREQ;
      cmd_src_pkg::SRC_TERM4:  freq_next = TERM4_FREQ;
      cmd_src_pkg::SRC_INCH:   freq_next = INCH_FREQ;
      cmd_src_pkg::SRC_LINK:   freq_next = link_freq_reg;
      default:                 freq_next = TERM2_FREQ;
    endcase
    if (mode_sel_reg == cmd_src_pkg::MODE_SEL_COMB2 || (keypad_reg && !link_valid_reg)) begin
      // panel keys start in mode 4 and in keypad mode while no link command is held
      run_next = panel_run_reg;
      rev_next = panel_rev_reg;
    end else if (keypad_reg) begin
      run_next = link_run_reg;
      rev_next = link_rev_reg;
    end else begin
      // external switches start in mode 3 and terminal mode
      run_next = fwd_s ^ bwd_s;
      rev_next = bwd_s && !fwd_s;
    end
  end

  // registered outputs to the drive
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      RUN_CMD        <= 1'b0;
      REVERSE_CMD    <= 1'b0;
      FREQ_CMD       <= cmd_src_pkg::FREQ_RESET;
      KEYPAD_MODE    <= 1'b0;
      LINK_CMD_TAKEN <= 1'b0;
    end else begin
      RUN_CMD        <= run_next;
      REVERSE_CMD    <= rev_next;
      FREQ_CMD       <= freq_next;
      KEYPAD_MODE    <= keypad_reg;
      LINK_CMD_TAKEN <= link_take;
    end
  end

  // ************************************************************
  // AXI4-Lite read channel
  // ************************************************************
  logic [31:0] rd_data;
  assign rd_fire = S_AXI_ARVALID && S_AXI_ARREADY;
  always_comb begin
    rd_data = 32'h00000000;
    case (S_AXI_ARADDR)
      cmd_src_pkg::OFF_MODE_SEL: rd_data[2:0] = mode_sel_reg;
      cmd_src_pkg::OFF_CONTROL:  rd_data[cmd_src_pkg::CTRL_DIAL_LOCK] = dial_lock_reg;
      cmd_src_pkg::OFF_STATUS: begin
        rd_data[cmd_src_pkg::STAT_KEYPAD_MODE] = keypad_reg;
        rd_data[cmd_src_pkg::STAT_RUN]         = RUN_CMD;
        rd_data[cmd_src_pkg::STAT_REVERSE]     = REVERSE_CMD;
        rd_data[cmd_src_pkg::STAT_WR_REJECT]   = wr_reject_reg;
        rd_data[cmd_src_pkg::STAT_MODE_LSB +: 3] = mode_sel_reg;
        rd_data[cmd_src_pkg::STAT_SRC_LSB +: 3]  = src;
      end
      cmd_src_pkg::OFF_KEY_FREQ: rd_data[FW-1:0] = key_freq_reg;
      cmd_src_pkg::OFF_PARAM_WR: rd_data[15:0]   = param_store_reg;
      cmd_src_pkg::OFF_FREQ_OUT: rd_data[FW-1:0] = FREQ_CMD;
      default: ;
    endcase
  end

  // one read at a time; unmapped reads answer SLVERR
  always_ff @(posedge REF_CLK) begin
    if (!NRST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h00000000;
      S_AXI_RRESP   <= cmd_src_pkg::RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID;
      if (rd_fire) begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID  <= 1'b1;
        S_AXI_RDATA   <= rd_data;
        S_AXI_RRESP   <= (S_AXI_ARADDR > cmd_src_pkg::OFF_FREQ_OUT || S_AXI_ARADDR[1:0] != 2'h0)
                         ? cmd_src_pkg::RESP_SLVERR : cmd_src_pkg::RESP_OKAY;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  chk_locked_modes: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (mode_sel_reg == cmd_src_pkg::MODE_SEL_EXT_FIXED) |-> !keypad_reg)
    else $error("locked mode left outside-terminal operation");
  chk_keypad_fixed: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (mode_sel_reg == cmd_src_pkg::MODE_SEL_PU_FIXED) |-> keypad_reg)
    else $error("mode one not in keypad operation");
  chk_link_gate: assert property (@(posedge REF_CLK) disable iff (!NRST)
    LINK_CMD_TAKEN |-> KEYPAD_MODE && $past(LINK_CMD_VALID))
    else $error("link command taken outside keypad mode");
  chk_mode_stopped: assert property (@(posedge REF_CLK) disable iff (!NRST)
    $changed(mode_sel_reg) |-> $past(MOTOR_STOPPED))
    else $error("mode changed while running");
  chk_multi_first: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (mode_sel_reg == cmd_src_pkg::MODE_SEL_COMB1 && multi_s) |-> src == cmd_src_pkg::SRC_MULTI)
    else $error("multi-speed did not win");
  chk_term4_pick: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (mode_sel_reg == cmd_src_pkg::MODE_SEL_COMB1 && !multi_s && !loop_s && cic_s)
    |-> ##1 FREQ_CMD == $past(TERM4_FREQ))
    else $error("terminal 4 not used");
  chk_bad_mode: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (wr_fire && aw_addr_reg == cmd_src_pkg::OFF_MODE_SEL && new_mode > cmd_src_pkg::MODE_SEL_COMB2)
    |=> $stable(mode_sel_reg) && $stable(keypad_reg))
    else $error("unsupported mode value took effect");
  chk_ext_start: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (mode_sel_reg == cmd_src_pkg::MODE_SEL_COMB1 && fwd_s && !bwd_s) |=> RUN_CMD)
    else $error("external start ignored in mode three");
  cov_toggle: cover property (@(posedge REF_CLK) disable iff (!NRST)
    !keypad_reg ##1 keypad_reg);
  cov_link: cover property (@(posedge REF_CLK) disable iff (!NRST) LINK_CMD_TAKEN);
  cov_reject: cover property (@(posedge REF_CLK) disable iff (!NRST) wr_fire && !wr_ok);
endmodule // drive_command_source_selector

// File: testbench/panel_model.sv
`timescale 1ns/1ps
// ****
// keypad, terminals and link far side
// ****
module panel_model (
  input  wire logic   clk,
  input  wire logic   send,
  output logic        valid,
  output logic [15:0] t2, t4, mf, lp, inch, dial, lnk
);
  // levels all differ so a wrong pick shows
  assign {t2, t4, mf, lp} = {16'h0102, 16'h0204, 16'h0308, 16'h0410};
  assign {inch, dial, lnk} = {16'h0520, 16'h0640, 16'h0780};
  // link frame ends as a one cycle strobe
  always_ff @(posedge clk) begin
    valid <= send;
  end
endmodule // panel_model

// File: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic c = 0, nr = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, ms = 1, snd = 0, tk = 0;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0;
  logic [13:0] p = 0;
  int n_mismatch = 0, tests_run = 0;
  wire logic aw_r, w_r, bv, ar_r, rv, lv, run, panel_backward_key, kp, tkn;
  wire logic [1:0] br, rr;
  wire logic [31:0] rdd;
  wire logic [15:0] t2, t4, mf, lp, inch, dial, lnk, fq;
  initial forever #2 c = ~c;
  panel_model panel_model_inst (.clk(c), .send(snd), .valid(lv), .t2(t2), .t4(t4),
    .mf(mf), .lp(lp), .inch(inch), .dial(dial), .lnk(lnk));
  drive_command_source_selector drive_command_source_selector_inst (.REF_CLK(c), .NRST(nr),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(aw_r), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(w_r), .S_AXI_BRESP(br),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(bre), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(ar_r), .S_AXI_RDATA(rdd), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rre), .FORWARD_START(p[0]), .BACKWARD_START(p[1]),
    .CURRENT_INPUT_CHOOSE(p[2]), .SPEED_SELECT_LOW(p[3]), .SPEED_SELECT_MID(p[4]),
    .SPEED_SELECT_HIGH(p[5]), .SPEED_SELECT_EXTRA(p[6]), .PROCESS_LOOP_ENABLE(p[7]),
    .INCH_RUN_SIGNAL(p[8]), .MODE_TOGGLE_KEY(p[9]), .PANEL_GO_KEY(p[10]),
    .PANEL_FORWARD_KEY(p[11]), .PANEL_BACKWARD_KEY(p[12]), .PANEL_STOP_KEY(p[13]),
    .TERM2_FREQ(t2), .TERM4_FREQ(t4), .MULTI_FREQ(mf), .LOOP_FREQ(lp), .INCH_FREQ(inch),
    .DIAL_FREQ(dial), .LINK_CMD_VALID(lv), .LINK_CMD_RUN(1'b1), .LINK_CMD_REVERSE(1'b0),
    .LINK_CMD_FREQ(lnk), .MOTOR_STOPPED(ms), .RUN_CMD(run), .REVERSE_CMD(panel_backward_key),
    .FREQ_CMD(fq), .KEYPAD_MODE(kp), .LINK_CMD_TAKEN(tkn));
  // sticky seen flag, the taken strobe lasts one cycle only
  always @(posedge c) if (tkn === 1'b1) tk <= 1;
  // ****
  // checks, bus tasks and the closing report
  // ****
  task automatic results;
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic ck(input logic [31:0] g, e);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  // a used-up wait bound ends the run at once
  task automatic lim(input logic ok);
    if (ok !== 1'b1) begin
      n_mismatch++;
      results();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge c);
    {awa, wd, awv, wv, bre} <= {a, d, 3'h7};
    repeat (40) begin
      @(posedge c);
      if (aw_r) awv <= 0;
      if (w_r) wv <= 0;
      if (bv) break;
    end
    bre <= 0;
    lim(bv);
    ck(br, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge c);
    {ara, arv, rre} <= {a, 2'h3};
    repeat (40) begin
      @(posedge c);
      if (ar_r) arv <= 0;
      if (rv) break;
    end
    rre <= 0;
    lim(rv);
    ck(rdd, e);
    ck(rr, r);
  endtask
  // pins pass two sync stages, so allow six edges
  task automatic pc(input logic [13:0] v, input logic [31:0] e);
    @(posedge c);
    p <= v;
    repeat (6) @(posedge c);
    ck({13'h0, kp, panel_backward_key, run, fq}, e);
  endtask
  task automatic lk;
    @(posedge c);
    snd <= 1;
    @(posedge c);
    snd <= 0;
    repeat (6) @(posedge c);
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    repeat (8) @(posedge c);
    nr <= 1;
    rd(8'h00, 32'h0, 2'h0);
    pc(14'h0001, 32'h1_0102);
    pc(14'h0002, 32'h3_0102);
    pc(14'h0009, 32'h1_0308);
    pc(14'h0005, 32'h1_0204);
    pc(14'h0101, 32'h1_0520);
    wr(8'h10, 32'h100, 2'h2);
    wr(8'h10, 32'h001, 2'h0);
    lk();
    ck(tk, 0);
    pc(14'h0200, 32'h4_0640);
    lk();
    ck(tk, 1);
    pc(14'h0000, 32'h5_0780);
    pc(14'h0200, 32'h0_0102);
    wr(8'h00, 32'h2, 2'h0);
    pc(14'h0000, 32'h0_0102);
    pc(14'h0200, 32'h0_0102);
    wr(8'h00, 32'h1, 2'h0);
    pc(14'h0400, 32'h5_0640);
    wr(8'h04, 32'h1, 2'h0);
    wr(8'h0c, 32'h0abc, 2'h0);
    pc(14'h0200, 32'h5_0abc);
    pc(14'h0000, 32'h5_0abc);
    wr(8'h00, 32'h3, 2'h0);
    pc(14'h0001, 32'h1_0abc);
    pc(14'h0011, 32'h1_0308);
    pc(14'h0005, 32'h1_0204);
    pc(14'h0085, 32'h1_0410);
    pc(14'h0095, 32'h1_0308);
    pc(14'h0201, 32'h1_0abc);
    pc(14'h0000, 32'h0_0abc);
    wr(8'h00, 32'h4, 2'h0);
    pc(14'h0400, 32'h1_0102);
    pc(14'h1000, 32'h3_0102);
    ms <= 0;
    wr(8'h00, 32'h0, 2'h2);
    ms <= 1;
    wr(8'h00, 32'h5, 2'h2);
    rd(8'h08, 32'h54e, 2'h0);
    pc(14'h2000, 32'h2_0102);
    pc(14'h0800, 32'h1_0102);
    wr(8'h40, 32'h0, 2'h2);
    rd(8'h40, 32'h0, 2'h2);
    results();
  end
endmodule // testbench
